// ==== inc/fsdsr_pkg.sv ====
// constants for the fieldbus slave diagnostic and status register group
// Function
// - user diag write forwarded high priority
// - user diag word mirrored at 1307
// - error status word mirrored at 1308
// - general error suspends cyclic, sends diag
// - stop to run clears all but 3,4,12,13
// - general error is OR bit1, 8..13
// - bit1 set in stop, cleared in run
// - bit2 follows diagnostics status flag
// - bit3 hardware fault, bit4 address store corrupt
// - bit5 consistency error, bit6 setting error
// - bit8 watchdog timeout, bit9 acyclic error
// - bit10 bad config, bit11 bad parameters
// - bit12 station address invalid or above 126
// - bit13 lock cleared in exchange or locked
// - fixed read-only module identification word
// - master address reads 00ff when unrecognized
// - group bits 0..7, zero means none
// - acyclic bit0 while extended service enabled
// - acyclic bit2 tracks switch word bit0
// - class-1 general bit8 from 9,10,alarm,delay
// - class-2 general bit12 from 13,14,15,delay
// - class-2 transport bit15 on failure or delay
// - acyclic error aborts service, reports master
// - lock flag set by forbid command
package fsdsr_pkg;
  localparam logic [11:0] IDX_COMM   = 12'h019;
  localparam logic [11:0] IDX_USER   = 12'h01c;
  localparam logic [11:0] IDX_ERR    = 12'h01d;
  localparam logic [11:0] IDX_ID     = 12'h01e;
  localparam logic [11:0] IDX_MADDR  = 12'h021;
  localparam logic [11:0] IDX_GROUP  = 12'h022;
  localparam logic [11:0] IDX_ACYC   = 12'h023;
  localparam logic [11:0] IDX_SWITCH = 12'h513;
  localparam logic [11:0] IDX_MIRU   = 12'h51b;
  localparam logic [11:0] IDX_MIRE   = 12'h51c;
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] MADDR_NONE = 16'h00ff;
  localparam logic [7:0]  ADDR_MAX   = 8'h7e;
  localparam logic [15:0] ERR_KEEP   = 16'h3018;
  localparam logic [15:0] ERR_STICKY = 16'h3f78;
  localparam logic [15:0] ERR_GEN    = 16'h3f02;
  localparam int          B_GEN      = 0;
  localparam int          B_STOP     = 1;
  localparam int          B_DIAG     = 2;
  localparam int          B_ACYC     = 9;
  localparam int          B_LOCK     = 8;
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

// ==== design/fsdsr_regs.sv ====
// fieldbus slave diagnostic and status register group with axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
module fsdsr_regs #(
  parameter logic [15:0] MODULE_ID = 16'h0a5a  // arbitrary value
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite write address
  input  wire logic [fsdsr_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         awvalid,
  output var  logic                         awready,
  // axi4-lite write data
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output var  logic                         wready,
  // axi4-lite write response
  output var  logic [1:0]                   bresp,
  output var  logic                         bvalid,
  input  wire logic                         bready,
  // axi4-lite read address
  input  wire logic [fsdsr_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                   arprot,
  input  wire logic                         arvalid,
  output var  logic                         arready,
  // axi4-lite read data
  output var  logic [31:0]                  rdata,
  output var  logic [1:0]                   rresp,
  output var  logic                         rvalid,
  input  wire logic                         rready,
  // host controller and link status
  input  wire logic                         plc_run,
  input  wire logic                         diag_flag,
  input  wire logic                         data_exchange,
  input  wire logic                         lock_access_dis,
  input  wire logic                         lock_forbid_cmd,
  // fault events
  input  wire logic                         hw_fault,
  input  wire logic                         addr_store_bad,
  input  wire logic                         consistency_err,
  input  wire logic                         setting_err,
  input  wire logic                         wdog_timeout,
  input  wire logic                         cfg_err,
  input  wire logic                         prm_err,
  input  wire logic                         addr_req,
  input  wire logic [7:0]                   addr_req_val,
  input  wire logic                         addr_req_inval,
  // acyclic service state and events
  input  wire logic                         ext_acyc_en,
  input  wire logic                         c1_read_err,
  input  wire logic                         c1_write_err,
  input  wire logic                         alarm_err,
  input  wire logic                         c1_delay_err,
  input  wire logic                         c2_read_err,
  input  wire logic                         c2_write_err,
  input  wire logic                         c2_transport_err,
  input  wire logic                         c2_delay_err,
  // master station information
  input  wire logic                         master_known,
  input  wire logic [7:0]                   master_addr,
  input  wire logic [7:0]                   group_bits,
  // diagnostics towards the bus master
  output var  logic                         diag_hp_req,
  output var  logic [15:0]                  diag_user_word,
  output var  logic [15:0]                  diag_err_word,
  output var  logic                         cyclic_suspend,
  output var  logic                         acyc_abort,
  output var  logic                         addr_lock
);

  // register index from a byte address, or all ones off the word grid
  function automatic logic [11:0] idx_of(input logic [fsdsr_pkg::ADDR_W-1:0] a);
    idx_of = (a[1:0] == 2'h0) ? a[13:2] : 12'hfff;
    if (a[fsdsr_pkg::ADDR_W-1:14] != 2'h0)
    begin
      idx_of = 12'hfff;
    end
  endfunction

  // true when an index names a register of this group
  function automatic logic is_mapped(input logic [11:0] i);
    is_mapped = (i == fsdsr_pkg::IDX_COMM) || (i == fsdsr_pkg::IDX_USER) ||
                (i == fsdsr_pkg::IDX_ERR) || (i == fsdsr_pkg::IDX_ID) ||
                (i == fsdsr_pkg::IDX_MADDR) || (i == fsdsr_pkg::IDX_GROUP) ||
                (i == fsdsr_pkg::IDX_ACYC) || (i == fsdsr_pkg::IDX_SWITCH) ||
                (i == fsdsr_pkg::IDX_MIRU) || (i == fsdsr_pkg::IDX_MIRE);
  endfunction

  // write path holding registers, run edge delay, switch bit and acyclic status
  logic        aw_ok;
  logic        w_ok;
  logic [11:0] aw_idx;
  logic [15:0] w_val;
  logic [15:0] w_mask;
  logic        run_q;
  logic        alarm_sw;
  logic [15:0] acyc_st;

  wire wr_en     = aw_ok & w_ok & ~bvalid;
  wire wr_user   = wr_en & ((aw_idx == fsdsr_pkg::IDX_USER) | (aw_idx == fsdsr_pkg::IDX_MIRU));
  wire wr_err    = wr_en & ((aw_idx == fsdsr_pkg::IDX_ERR) | (aw_idx == fsdsr_pkg::IDX_MIRE));
  wire wr_comm   = wr_en & (aw_idx == fsdsr_pkg::IDX_COMM);
  wire wr_switch = wr_en & (aw_idx == fsdsr_pkg::IDX_SWITCH);
  wire [15:0] user_merged = (diag_user_word & ~w_mask) | (w_val & w_mask);
  wire [15:0] err_merged  = (diag_err_word & ~w_mask) | (w_val & w_mask);

  // lock flag: forbid command sets, host write of zero clears unless lock_access_dis is high
  wire lock_clr_try = wr_comm & w_mask[fsdsr_pkg::B_LOCK] & ~w_val[fsdsr_pkg::B_LOCK] & addr_lock;
  wire lock_clr     = lock_clr_try & ~lock_access_dis;
  wire next_lock    = lock_forbid_cmd | (addr_lock & ~lock_clr);
  wire lock_bad     = lock_clr_try & (data_exchange | lock_access_dis);

  // station address request check
  wire addr_bad = addr_req & (addr_req_inval | (addr_req_val > fsdsr_pkg::ADDR_MAX));

  // acyclic service error bookkeeping
  wire [15:0] acyc_ev = {c2_transport_err | c2_delay_err,
                         c2_write_err, c2_read_err, c2_delay_err, 1'b0,
                         c1_write_err, c1_read_err, alarm_err | c1_delay_err, 8'h00};
  wire acyc_any_ev = |acyc_ev;
  wire acyc_clr    = wr_err & w_mask[fsdsr_pkg::B_ACYC] & ~w_val[fsdsr_pkg::B_ACYC];
  wire [15:0] next_acyc_st = (acyc_clr ? fsdsr_pkg::RST_ZERO : acyc_st) | acyc_ev;
  wire [15:0] acyc_word = {next_acyc_st[15:13] & 3'h7, next_acyc_st[15:12] != 4'h0,
                           1'b0, acyc_st[10:9],
                           acyc_st[10:8] != 3'h0,
                           5'h00, alarm_sw,
                           1'b0, ext_acyc_en};

  // error status events, one bit each
  wire [15:0] err_ev = {2'h0, lock_bad, addr_bad, prm_err, cfg_err,
                        acyc_any_ev, wdog_timeout,
                        1'b0, setting_err, consistency_err,
                        addr_store_bad, hw_fault,
                        3'h0};
  wire run_rise = plc_run & ~run_q;

  // host write, then stop-to-run clear, then events win over both
  wire [15:0] err_wr    = wr_err ? err_merged : diag_err_word;
  wire [15:0] err_run   = run_rise ? (err_wr & fsdsr_pkg::ERR_KEEP) : err_wr;
  wire [15:0] err_stick = (err_run | err_ev) & fsdsr_pkg::ERR_STICKY;
  wire [15:0] err_lvl   = err_stick | {13'h0, diag_flag, ~plc_run, 1'b0};
  wire        next_gen  = |(err_lvl & fsdsr_pkg::ERR_GEN);
  wire [15:0] next_err  = err_lvl | {15'h0, next_gen};

  // read selection
  wire [11:0] ar_idx = idx_of(araddr);
  wire [15:0] maddr_word = master_known ? {8'h00, master_addr} : fsdsr_pkg::MADDR_NONE;
  wire [15:0] comm_word  = {7'h00, addr_lock, 5'h00, diag_flag, 2'h0};
  wire [15:0] rd_val =
    (ar_idx == fsdsr_pkg::IDX_COMM)   ? comm_word :
    (ar_idx == fsdsr_pkg::IDX_USER)   ? diag_user_word :
    (ar_idx == fsdsr_pkg::IDX_MIRU)   ? diag_user_word :
    (ar_idx == fsdsr_pkg::IDX_ERR)    ? diag_err_word :
    (ar_idx == fsdsr_pkg::IDX_MIRE)   ? diag_err_word :
    (ar_idx == fsdsr_pkg::IDX_ID)     ? MODULE_ID :
    (ar_idx == fsdsr_pkg::IDX_MADDR)  ? maddr_word :
    (ar_idx == fsdsr_pkg::IDX_GROUP)  ? {8'h00, group_bits} :
    (ar_idx == fsdsr_pkg::IDX_ACYC)   ? acyc_word :
    (ar_idx == fsdsr_pkg::IDX_SWITCH) ? {15'h0, alarm_sw} :
    fsdsr_pkg::RST_ZERO;

  // write address and data, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_ok   <= 1'b0;
      w_ok    <= 1'b0;
      aw_idx  <= 12'h000;
      w_val   <= fsdsr_pkg::RST_ZERO;
      w_mask  <= fsdsr_pkg::RST_ZERO;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_ok   <= 1'b1;
        aw_idx  <= idx_of(awaddr);
      end
      else if (wr_en)
      begin
        aw_ok <= 1'b0;
      end
      else if (bvalid && bready)
      begin
        awready <= 1'b1;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_ok   <= 1'b1;
        w_val  <= wdata[15:0];
        w_mask <= {{8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      else if (wr_en)
      begin
        w_ok <= 1'b0;
      end
      else if (bvalid && bready)
      begin
        wready <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= fsdsr_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_idx) ? fsdsr_pkg::RESP_OKAY : fsdsr_pkg::RESP_SLV;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= fsdsr_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {16'h0000, rd_val};
      rresp   <= is_mapped(ar_idx) ? fsdsr_pkg::RESP_OKAY : fsdsr_pkg::RESP_SLV;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // user diagnostic word and its forwarding request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      diag_user_word <= fsdsr_pkg::RST_ZERO;
      diag_hp_req    <= 1'b0;
    end
    else
    begin
      diag_hp_req <= wr_user;
      if (wr_user)
      begin
        diag_user_word <= user_merged;
      end
    end
  end

  // error status, general error, suspension of cyclic exchange
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      diag_err_word  <= fsdsr_pkg::RST_ZERO;
      cyclic_suspend <= 1'b0;
      run_q          <= 1'b0;
    end
    else
    begin
      diag_err_word  <= next_err;
      cyclic_suspend <= next_gen;
      run_q          <= plc_run;
    end
  end

  // acyclic status, switch bit and address lock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acyc_st    <= fsdsr_pkg::RST_ZERO;
      acyc_abort <= 1'b0;
      alarm_sw   <= 1'b0;
      addr_lock  <= 1'b0;
    end
    else
    begin
      acyc_st    <= next_acyc_st;
      acyc_abort <= acyc_any_ev;
      addr_lock  <= next_lock;
      if (wr_switch && w_mask[0])
      begin
        alarm_sw <= w_val[0];
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_user_wr;
    wr_user;
  endsequence
  sequence s_user_fwd;
    diag_hp_req && (diag_user_word == $past(user_merged));
  endsequence
  sequence s_acyc_ev;
    acyc_any_ev && !acyc_clr;
  endsequence
  sequence s_acyc_rep;
    acyc_abort && diag_err_word[fsdsr_pkg::B_ACYC];
  endsequence

  AST_USER_FWD: assert property (s_user_wr |=> s_user_fwd)
    else $error("user diagnostic write not forwarded");
  AST_GEN_OR: assert property (diag_err_word[0] == (|(diag_err_word & fsdsr_pkg::ERR_GEN)))
    else $error("general error bit disagrees with its sources");
  AST_SUSPEND: assert property (cyclic_suspend == diag_err_word[0])
    else $error("cyclic suspension does not follow general error");
  AST_RUN_CLR: assert property ($rose(plc_run) && !consistency_err |=> !diag_err_word[5])
    else $error("consistency bit survived stop to run");
  AST_RUN_KEEP: assert property ($rose(plc_run) && diag_err_word[13] && !wr_err |=> diag_err_word[13])
    else $error("bit 13 lost at stop to run");
  AST_STOP: assert property (!plc_run |=> diag_err_word[1] ##1 (plc_run || diag_err_word[1]))
    else $error("stop bit not set in stop mode");
  AST_ADDR: assert property (addr_req && addr_req_val > fsdsr_pkg::ADDR_MAX |=> diag_err_word[12])
    else $error("bad station address not flagged");
  AST_MADDR: assert property (arvalid && arready && ar_idx == fsdsr_pkg::IDX_MADDR && !master_known
                              |=> rvalid && rdata[15:0] == fsdsr_pkg::MADDR_NONE)
    else $error("unrecognized master address not 00ff");
  AST_ACYC: assert property (s_acyc_ev |=> s_acyc_rep)
    else $error("acyclic error not aborted and reported");
  AST_LOCK: assert property (lock_forbid_cmd |=> addr_lock)
    else $error("lock flag not set by forbid command");
  AST_DIAG: assert property (diag_flag |=> diag_err_word[2])
    else $error("not yet sent bit missing");

endmodule
`default_nettype wire

// ==== verif/fsdsr_link_model.sv ====
// far-side model: link master and host events delivered as single-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module fsdsr_link_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // request from the bench
  input  wire logic        ev_go,
  input  wire logic [4:0]  ev_idx,
  // event lines towards the device
  output var  logic [16:0] ev
);
  // faults are reported once, so each request lasts one cycle only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev <= 17'h00000;
    else
      ev <= ev_go ? (17'h00001 << ev_idx) : 17'h00000;
  end
endmodule
`default_nettype wire

// ==== verif/fsdsr_regs_tb.sv ====
// self-checking bench for the diagnostic and status register group
`timescale 1ns/1ns
`default_nettype none
module fsdsr_regs_tb;
  localparam logic [15:0] ID = 16'h3c96;  // arbitrary value
  logic        aclk;
  logic        aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, ev_go = 1'h0, run = 1'h0;
  logic        plc_run = 1'h0, diag_flag = 1'h0, data_exchange = 1'h0, lock_access_dis = 1'h0;
  logic        addr_req_inval = 1'h0, ext_acyc_en = 1'h0, master_known = 1'h0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, usr, m, diag_user_word, diag_err_word;
  logic [31:0] wdata = 32'h0, rd, rdata, seed = 32'hc1c9b960;
  logic [3:0]  wstrb = 4'h0;
  logic [7:0]  addr_req_val = 8'h00, master_addr = 8'h00, group_bits = 8'h00;
  logic [4:0]  ev_idx = 5'h00;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, diag_hp_req, cyclic_suspend, acyc_abort, addr_lock;
  logic [16:0] ev;
  int          fails = 0, check_count = 0, hp_n = 0, ab_n = 0, st = 0, ac = 0;
  int          eb [8] = '{3, 4, 5, 6, 8, 10, 11, 12};
  int          ob [8] = '{9, 10, 16, 16, 13, 14, 15, 15};

  fsdsr_regs #(.MODULE_ID(ID)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'h1), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .plc_run(plc_run), .diag_flag(diag_flag),
    .data_exchange(data_exchange), .lock_access_dis(lock_access_dis), .lock_forbid_cmd(ev[16]),
    .hw_fault(ev[0]), .addr_store_bad(ev[1]), .consistency_err(ev[2]), .setting_err(ev[3]),
    .wdog_timeout(ev[4]), .cfg_err(ev[5]), .prm_err(ev[6]), .addr_req(ev[7]), .addr_req_val(addr_req_val),
    .addr_req_inval(addr_req_inval), .ext_acyc_en(ext_acyc_en), .c1_read_err(ev[8]), .c1_write_err(ev[9]),
    .alarm_err(ev[10]), .c1_delay_err(ev[11]), .c2_read_err(ev[12]), .c2_write_err(ev[13]),
    .c2_transport_err(ev[14]), .c2_delay_err(ev[15]), .master_known(master_known),
    .master_addr(master_addr), .group_bits(group_bits), .diag_hp_req(diag_hp_req),
    .diag_user_word(diag_user_word), .diag_err_word(diag_err_word), .cyclic_suspend(cyclic_suspend),
    .acyc_abort(acyc_abort), .addr_lock(addr_lock));

  fsdsr_link_model u_link (.aclk(aclk), .aresetn(aresetn), .ev_go(ev_go), .ev_idx(ev_idx), .ev(ev));

  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // pulse counters for the one-cycle outputs
  always @(posedge aclk)
  begin
    if (diag_hp_req === 1'h1) hp_n++;
    if (acyc_abort === 1'h1) ab_n++;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // expected error word from sticky bits and levels
  function automatic logic [15:0] errx();
    logic [15:0] e;
    e = 16'(st) | {13'h0, diag_flag, ~run, 1'h0};
    return e | {15'h0, |(e & fsdsr_pkg::ERR_GEN)};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      n++;
    end
    while (bvalid !== 1'h1 && n < 50);
    rs = bresp;
    if (n >= 50) chk(32'h0, 32'h1, "write hang");
  endtask

  task automatic axr(input logic [15:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      n++;
    end
    while (rvalid !== 1'h1 && n < 50);
    rd = rdata;
    rs = rresp;
    if (n >= 50) chk(32'h0, 32'h1, "read hang");
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string msg);
    axr(a);
    chk(rd, e, msg);
    chk({30'h0, rs}, {30'h0, fsdsr_pkg::RESP_OKAY}, msg);
  endtask

  task automatic pulse(input int i);
    ev_idx <= 5'(i);
    ev_go <= 1'h1;
    @(posedge aclk);
    ev_go <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic errchk(input string msg);
    logic [15:0] e;
    repeat (2) @(posedge aclk);
    e = errx();
    chk({16'h0, diag_err_word}, {16'h0, e}, msg);
    chk({31'h0, cyclic_suspend}, {31'h0, e[0]}, msg);
    rchk(16'h0074, {16'h0, e}, msg);
    rchk(16'h1470, {16'h0, e}, msg);
  endtask

  task automatic evloop(input int n);
    for (int i = 0; i < n; i++)
    begin
      pulse(i);
      st |= 1 << eb[i];
      errchk("fault event");
    end
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    seed = xs(seed);
    master_addr <= seed[7:0];
    group_bits <= seed[15:8];
    ext_acyc_en <= 1'h1;
    ac = 1;
    errchk("after reset");
    rchk(16'h0078, {16'h0, ID}, "module id");
    rchk(16'h0084, 32'h00ff, "master unknown");
    rchk(16'h0088, {24'h0, group_bits}, "groups");
    rchk(16'h008c, 32'(ac), "acyclic enable");
    master_known <= 1'h1;
    group_bits <= 8'h00;
    axw(16'h0078, 32'hffff, 4'h3);
    chk({30'h0, rs}, {30'h0, fsdsr_pkg::RESP_OKAY}, "read-only write");
    rchk(16'h0078, {16'h0, ID}, "id after write");
    rchk(16'h0084, {24'h0, master_addr}, "master known");
    rchk(16'h0088, 32'h0, "no groups");
    axr(16'h0200);
    chk({30'h0, rs}, {30'h0, fsdsr_pkg::RESP_SLV}, "unmapped");
    axw(16'h0200, 32'hffff, 4'h3);
    chk({30'h0, rs}, {30'h0, fsdsr_pkg::RESP_SLV}, "unmapped write");
    $display("test identity finished");
    usr = 16'h0000;
    for (int k = 1; k < 4; k++)
    begin
      seed = xs(seed);
      m = {{8{k[1]}}, {8{k[0]}}};
      usr = (usr & ~m) | (seed[15:0] & m);
      axw(16'h0070, seed, 4'(k));
      repeat (2) @(posedge aclk);
      chk(32'(hp_n), 32'(k), "hp request");
      chk({16'h0, diag_user_word}, {16'h0, usr}, "user out");
      rchk(16'h146c, {16'h0, usr}, "user mirror");
    end
    seed = xs(seed);
    axw(16'h146c, seed, 4'h3);
    rchk(16'h0070, {16'h0, seed[15:0]}, "mirror write");
    $display("test user word finished");
    for (int i = 8; i < 16; i++)
    begin
      pulse(i);
      ac |= 1 << ob[i - 8];
      ac |= (i < 12) ? 32'h100 : 32'h1000;
      st |= 32'h200;
      chk(32'(ab_n), 32'(i - 7), "abort pulse");
      rchk(16'h008c, {16'h0, 16'(ac)}, "acyclic word");
      errchk("acyclic error");
    end
    axw(16'h144c, 32'h1, 4'h3);
    rchk(16'h008c, {16'h0, 16'(ac | 4)}, "switch on");
    axw(16'h144c, 32'h0, 4'h3);
    rchk(16'h008c, {16'h0, 16'(ac)}, "switch off");
    $display("test acyclic finished");
    addr_req_val <= 8'h7e;
    pulse(7);
    errchk("address 126");
    addr_req_val <= 8'h7f;
    evloop(8);
    axw(16'h0074, 32'h0, 4'h3);
    st = 0;
    ac &= 5;
    errchk("host clear");
    rchk(16'h008c, {16'h0, 16'(ac)}, "acyclic cleared");
    addr_req_val <= 8'h05;
    addr_req_inval <= 1'h1;
    pulse(7);
    st = 32'h1000;
    errchk("invalid address");
    addr_req_inval <= 1'h0;
    evloop(7);
    diag_flag <= 1'h1;
    errchk("diag flag");
    diag_flag <= 1'h0;
    $display("test faults finished");
    pulse(16);
    chk({31'h0, addr_lock}, 32'h1, "lock set");
    data_exchange <= 1'h1;
    axw(16'h0064, 32'hfeff, 4'h3);
    st |= 32'h2000;
    errchk("lock clear in exchange");
    chk({31'h0, addr_lock}, 32'h0, "lock cleared");
    data_exchange <= 1'h0;
    axw(16'h0074, 32'h0, 4'h2);
    st &= 32'h00ff;
    errchk("upper error bits cleared");
    lock_access_dis <= 1'h1;
    pulse(16);
    axw(16'h0064, 32'hfeff, 4'h3);
    chk({31'h0, addr_lock}, 32'h1, "lock kept");
    st |= 32'h2000;
    errchk("lock clear refused");
    lock_access_dis <= 1'h0;
    $display("test lock finished");
    plc_run <= 1'h1;
    run = 1'h1;
    st &= 32'h3018;
    errchk("stop to run");
    axw(16'h0074, 32'h0018, 4'h3);
    st = 32'h0018;
    errchk("no general error");
    plc_run <= 1'h0;
    run = 1'h0;
    errchk("back to stop");
    $display("test run mode finished");
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
